/* tb_top.sv */
// Self-checking bench for the trim counter
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import utcn_pkg::*;
  // Write time shortened so a store fits in a short run
  localparam int WR_CYC = 20;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  utcn_adj_flags_type flags;
  logic count_enable;
  logic [CODE_W-1:0] trim_code;
  logic [SETTING_W-1:0] sink_current_output;
  logic nvm_busy;
  logic trim_ready;
  int error_cnt = 0;
  int tests_run = 0;
  int busy_cyc = 0;
  always #10 sys_clk = ~sys_clk;
  utcn_fixture fix (.sys_clk(sys_clk), .flags(flags), .count_enable(count_enable));
  utcn_top #(.WRITE_CYCLES(WR_CYC)) DUT (.sys_clk(sys_clk), .rst(rst), .adjust_program_input(flags),
    .count_enable(count_enable), .trim_code(trim_code), .sink_current_output(sink_current_output),
    .nvm_busy(nvm_busy), .trim_ready(trim_ready));
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Reset acts as power-on; load lands a few edges after release
  task do_reset(input logic [6:0] e);
    rst <= 1'b1;
    repeat (16) @(negedge sys_clk);
    rst <= 1'b0;
    repeat (5) @(negedge sys_clk);
    chk("ready", {7'h00, trim_ready}, 8'h01);
    chk("code", {1'b0, trim_code}, {1'b0, e});
    chk("setting", sink_current_output, {1'b0, e} + 8'h01);
  endtask
  // A pulse then the expected code
  task step(input logic [2:0] f, input int us, input logic [6:0] e, input string n);
    fix.pulse(f, us);
    chk(n, {1'b0, trim_code}, {1'b0, e});
  endtask
  // First pulse dropped, then single steps, then short pulses rejected
  task t_first_and_steps;
    step(3'h1, 201, NVM_BLANK, "first");
    step(3'h1, 201, NVM_BLANK + 7'h01, "inc");
    step(3'h2, 201, NVM_BLANK, "dec");
    step(3'h1, 10, NVM_BLANK, "short_low");
    step(3'h2, 10, NVM_BLANK, "short_high");
  endtask
  // No count with enable low
  task t_enable_low;
    fix.set_ce(1'b0);
    step(3'h1, 201, NVM_BLANK, "ce_low");
    fix.set_ce(1'b1);
  endtask
  // Program pulse while counting busy cycles; a lost write shows as zero
  task t_store(input logic [6:0] e, input string n);
    busy_cyc = 0;
    fork
      step(3'h6, 201, e, n);
      repeat (201 * TICK_CYC) @(negedge sys_clk) busy_cyc += nvm_busy;
    join
    chk("busy_cycles", 8'(busy_cyc), 8'(WR_CYC));
    chk("busy", {7'h00, nvm_busy}, 8'h00);
  endtask
  // Store with enable low, then with enable high (no decrement on release), then reload
  task t_program;
    fix.set_ce(1'b0);
    t_store(NVM_BLANK, "prog_ce_low");
    fix.set_ce(1'b1);
    step(3'h1, 201, NVM_BLANK + 7'h01, "pre_prog");
    t_store(NVM_BLANK + 7'h01, "prog_no_dec");
    fix.set_ce(1'b0);
    do_reset(NVM_BLANK + 7'h01);
  endtask
  initial begin
    do_reset(NVM_BLANK);
    t_first_and_steps();
    t_enable_low();
    t_program();
    end_sim();
  end
  // Whole sequence is about 1.45 ms; limit kept under 100k cycles
  initial begin
    #1900000;
    error_cnt++;
    end_sim();
  end
endmodule // tb_top

/* utcn_fixture.sv */
// Alignment fixture model driving the adjust flags and count enable
module utcn_fixture
  import utcn_pkg::*;
(
  input wire logic sys_clk,
  output utcn_adj_flags_type flags,
  output logic count_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle is the mid level: no comparator flag raised
  initial begin
    flags = '0;
    count_enable = 1'b1;
  end
  task set_ce(input logic v);
    @(negedge sys_clk) count_enable <= v;
  endtask
  task pulse(input logic [2:0] f, input int us);
    @(negedge sys_clk) flags <= f;
    repeat (us * TICK_CYC) @(negedge sys_clk);
    flags <= '0;
    // Mid gap lets the step land before the next check
    repeat (100) @(negedge sys_clk);
  endtask
endmodule // utcn_fixture

/* utcn_monitor.sv */
// Port checker for the trim counter
module utcn_monitor
  import utcn_pkg::*;
#(
  parameter int WRITE_CYCLES = 20
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire utcn_adj_flags_type adjust_program_input,
  input wire logic count_enable,
  input wire logic [CODE_W-1:0] trim_code,
  input wire logic [SETTING_W-1:0] sink_current_output,
  input wire logic nvm_busy,
  input wire logic trim_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BUSY_LIM = WRITE_CYCLES + 2;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // A step after the power-on load, not the load itself
  sequence s_step;
    $changed(trim_code) && $past(trim_ready);
  endsequence
  sequence s_up;
    s_step ##0 trim_code == 7'($past(trim_code) + 1);
  endsequence
  sequence s_dn;
    s_step ##0 trim_code == 7'($past(trim_code) - 1);
  endsequence
  a_reset_then_load: assert property ($fell(rst) |-> (trim_code == CODE_MIN && !nvm_busy && !trim_ready)
    ##[2:3] trim_ready) else $error("power-on load late");
  a_setting_map: assert property (sink_current_output == {1'b0, trim_code} + 8'h01)
    else $error("setting not code plus one");
  a_single_step: assert property (s_step |-> trim_code == 7'($past(trim_code) + 1)
    || trim_code == 7'($past(trim_code) - 1)) else $error("step not one");
  a_no_wrap: assert property (trim_ready && trim_code == CODE_MAX |=> trim_code != CODE_MIN)
    else $error("counter wrapped");
  a_ce_gates: assert property (s_step |-> $past(count_enable)) else $error("count without enable");
  // Low held about the full width right before the release
  a_inc_cause: assert property (s_up |-> $past(adjust_program_input.low, 2)
    && $past(adjust_program_input.low, 1001)) else $error("bad increment");
  a_dec_cause: assert property (s_dn |-> $past(adjust_program_input.high, 2)
    && $past(adjust_program_input.high, 1001)) else $error("bad decrement");
  a_prog_cause: assert property ($rose(nvm_busy) |-> $past(adjust_program_input.prog))
    else $error("write without program");
  a_write_span: assert property ($rose(nvm_busy) |-> nvm_busy[*8] ##[1:BUSY_LIM] !nvm_busy)
    else $error("write time wrong");
  c_step: cover property (s_step);
  c_write: cover property ($rose(nvm_busy));
  c_load: cover property ($fell(rst) ##[2:3] trim_ready);
endmodule // utcn_monitor

bind utcn_top utcn_monitor #(.WRITE_CYCLES(WRITE_CYCLES)) u_mon (.sys_clk(sys_clk), .rst(rst),
  .adjust_program_input(adjust_program_input), .count_enable(count_enable), .trim_code(trim_code),
  .sink_current_output(sink_current_output), .nvm_busy(nvm_busy), .trim_ready(trim_ready));

/* utcn_nvm_cell.sv */
// Non-volatile storage cell for the trim code with timed write.
module utcn_nvm_cell
  import utcn_pkg::*;
#(
  parameter int WRITE_CYCLES = WRITE_MAX_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire utcn_nvm_req_type req,
  output logic [CODE_W-1:0] rdata_q,
  output logic busy_q
);

  localparam int WCNT_W = $clog2(WRITE_CYCLES + 1);
  localparam logic [WCNT_W-1:0] WCNT_LAST = WCNT_W'(WRITE_CYCLES - 1);

  // Stored word survives reset, as a non-volatile cell must
  logic [CODE_W-1:0] cell_q = NVM_BLANK;
  logic [CODE_W-1:0] wdata_q;
  logic [WCNT_W-1:0] wcnt_q;
  wire start_wr = req.wr & ~busy_q;
  wire wr_done = busy_q & (wcnt_q == WCNT_LAST);

  // Write timer; new requests during a write are dropped
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      busy_q <= 1'b0;
      wcnt_q <= '0;
      wdata_q <= CODE_MIN;
    end else if (start_wr) begin
      busy_q <= 1'b1;
      wcnt_q <= '0;
      wdata_q <= req.data;
    end else if (wr_done) begin
      busy_q <= 1'b0;
    end else if (busy_q) begin
      wcnt_q <= wcnt_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (wr_done) begin
      cell_q <= wdata_q;
    end
  end

  // Registered read port
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_q <= CODE_MIN;
    end else if (req.rd) begin
      rdata_q <= cell_q;
    end
  end

endmodule // utcn_nvm_cell

/* utcn_pkg.sv */
// Constants and types shared by the trim counter and its non-volatile cell.
package utcn_pkg;

  localparam int CODE_W = 7;
  localparam int SETTING_W = 8;
  localparam logic [CODE_W-1:0] CODE_MIN = 7'h00;
  localparam logic [CODE_W-1:0] CODE_MAX = 7'h7F;
  // Value of a cell that has never been programmed (arbitrary mid-scale)
  localparam logic [CODE_W-1:0] NVM_BLANK = 7'h40;

  // Clock and microsecond tick
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Shortest accepted pulse, in microseconds and in ticks
  localparam int REJECT_US = 20;
  // One extra tick because the first tick lands at an arbitrary phase
  localparam int QUAL_TICKS = REJECT_US + 1;
  localparam int PULSE_CNT_W = $clog2(QUAL_TICKS + 1);

  // Longest internal write time, in milliseconds and cycles (rounded down)
  localparam int WRITE_MAX_MS = 100;
  localparam int WRITE_MAX_CYC = (WRITE_MAX_MS * 1000000) / CLK_PERIOD_NS;

  // Flag positions in the comparator vector
  localparam int FLAG_LOW = 0;
  localparam int FLAG_HIGH = 1;
  localparam int FLAG_PROG = 2;
  localparam int FLAG_N = 3;

  typedef struct packed {
    logic prog;
    logic high;
    logic low;
  } utcn_adj_flags_type;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [CODE_W-1:0] data;
  } utcn_nvm_req_type;

  typedef enum logic [1:0] {
    ST_LOAD_REQ = 2'b00,
    ST_LOAD_WAIT = 2'b01,
    ST_RUN = 2'b10
  } utcn_state_type;

endpackage

/* utcn_top.sv */
// Saturating up/down trim counter with pulse qualification and NVM store.
module utcn_top
  import utcn_pkg::*;
#(
  parameter int WRITE_CYCLES = WRITE_MAX_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire utcn_adj_flags_type adjust_program_input,
  input wire logic count_enable,
  output logic [CODE_W-1:0] trim_code,
  output logic [SETTING_W-1:0] sink_current_output,
  output logic nvm_busy,
  output logic trim_ready
);

  utcn_state_type state_q, state_d;
  logic [CODE_W-1:0] code_q, code_d;
  logic [SETTING_W-1:0] setting_q;
  logic ready_q;
  logic first_done_q;
  logic prog_seen_q;
  logic [7:0] tick_cnt_q;
  logic tick_q;
  logic [FLAG_N-1:0] flag_prev_q;
  logic [PULSE_CNT_W-1:0] pulse_cnt_q [FLAG_N];
  logic [CODE_W-1:0] nvm_rdata;
  logic nvm_busy_w;
  utcn_nvm_req_type nvm_req;

  localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);
  localparam logic [PULSE_CNT_W-1:0] QUAL_CNT = PULSE_CNT_W'(QUAL_TICKS);

  wire [FLAG_N-1:0] flag = {adjust_program_input.prog, adjust_program_input.high, adjust_program_input.low};

  // Microsecond tick divider keeps the pulse counters tiny
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tick_cnt_q <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (tick_cnt_q == TICK_LAST);
      tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? 8'h00 : tick_cnt_q + 8'h01;
    end
  end

  wire [FLAG_N-1:0] qualified;
  wire [FLAG_N-1:0] released_ok;
  genvar gi;
  generate
    for (gi = 0; gi < FLAG_N; gi++) begin : g_timer
      // Count saturates at the qualifying width; a dropped flag clears it
      always_ff @(posedge sys_clk) begin
        if (rst || !flag[gi]) begin
          pulse_cnt_q[gi] <= '0;
        end else if (tick_q && pulse_cnt_q[gi] != QUAL_CNT) begin
          pulse_cnt_q[gi] <= pulse_cnt_q[gi] + 1'b1;
        end
      end
      assign qualified[gi] = (pulse_cnt_q[gi] == QUAL_CNT);
      // Release back to mid after a long enough pulse
      assign released_ok[gi] = flag_prev_q[gi] & ~flag[gi] & qualified[gi];
    end
  endgenerate

  // Flag history for release detection
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flag_prev_q <= '0;
    end else begin
      flag_prev_q <= flag;
    end
  end

  wire prog_hit = flag[FLAG_PROG] & tick_q & (pulse_cnt_q[FLAG_PROG] == QUAL_CNT - 1'b1);

  // A high pulse that went on to program level is a store, not a decrement
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prog_seen_q <= 1'b0;
    end else if (flag[FLAG_PROG]) begin
      prog_seen_q <= 1'b1;
    end else if (!flag[FLAG_HIGH]) begin
      prog_seen_q <= 1'b0;
    end
  end

  wire inc_pulse = released_ok[FLAG_LOW];
  wire dec_pulse = released_ok[FLAG_HIGH] & ~prog_seen_q & ~flag[FLAG_PROG];
  wire any_pulse = inc_pulse | dec_pulse | prog_hit;
  wire running = (state_q == ST_RUN);
  wire pass = running & first_done_q;

  // Comparators start unknown, so the first whole pulse only arms the logic
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      first_done_q <= 1'b0;
    end else if (running && any_pulse) begin
      first_done_q <= 1'b1;
    end
  end

  wire do_inc = pass & inc_pulse & count_enable;
  wire do_dec = pass & dec_pulse & count_enable;
  wire do_prog = pass & prog_hit;

  // Power-on sequencing: read cell, wait for registered data, then run
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_LOAD_REQ: state_d = ST_LOAD_WAIT;
      ST_LOAD_WAIT: state_d = ST_RUN;
      ST_RUN: state_d = ST_RUN;
      default: state_d = ST_LOAD_REQ;
    endcase
  end

  wire at_max = (code_q == CODE_MAX);
  wire at_min = (code_q == CODE_MIN);
  always_comb begin
    code_d = code_q;
    if (state_q == ST_LOAD_WAIT) begin
      code_d = nvm_rdata;
    end else if (do_inc && !at_max) begin
      code_d = code_q + 1'b1;
    end else if (do_dec && !at_min) begin
      code_d = code_q - 1'b1;
    end
  end

  assign nvm_req = '{rd: (state_q == ST_LOAD_REQ), wr: do_prog, data: code_q};

  utcn_nvm_cell #(
    .WRITE_CYCLES(WRITE_CYCLES)
  ) u_cell (
    .sys_clk(sys_clk),
    .rst(rst),
    .req(nvm_req),
    .rdata_q(nvm_rdata),
    .busy_q(nvm_busy_w)
  );

  // State, counter and output registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= ST_LOAD_REQ;
      code_q <= CODE_MIN;
      setting_q <= 8'h01;
      ready_q <= 1'b0;
    end else begin
      state_q <= state_d;
      code_q <= code_d;
      setting_q <= {1'b0, code_d} + 8'h01;
      ready_q <= (state_d == ST_RUN);
    end
  end

  assign trim_code = code_q;
  assign sink_current_output = setting_q;
  assign nvm_busy = nvm_busy_w;
  assign trim_ready = ready_q;

endmodule // utcn_top
